// >>> bench/radio_spi_host.sv
// Host controller model driving the serial port in clock mode 0.
`timescale 1ns/1ps
module radio_spi_host (
  input  wire logic MCLK,
  input  wire logic SO,
  output logic      SCLK,
  output logic      CS_N,
  output logic      SI
);
  localparam int HALF = 8;
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SI   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic start();
    CS_N <= 1'b0;
    tick(HALF);
  endtask
  task automatic stop();
    tick(HALF);
    CS_N <= 1'b1;
    SI   <= ~SI;
    tick(HALF);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      SI <= tx[i];
      tick(HALF);
      rx[i] = SO;
      SCLK <= 1'b1;
      tick(HALF);
      SCLK <= 1'b0;
    end
  endtask
endmodule // radio_spi_host

// >>> bench/radio_spi_regs_bench.sv
// Self-checking bench for the radio serial register map.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module radio_spi_regs_bench
  import radio_regs_pkg::*;
;
  localparam logic [7:0] PID = 8'h3C; // Arbitrary value.
  logic        MCLK, RST, SCLK, CS_N, SI, SO, SO_OE, SLEEP, CHIP_READY_N, GPO0_LEVEL;
  logic        TX_UNDERFLOW, RX_OVERFLOW, GPO2, STROBE, TXF_WR, RXF_RD;
  logic [2:0]  STATUS_MODE, PWR_SEL;
  logic [4:0]  RADIO_STATE, PKT_FLAGS;
  logic [6:0]  TX_COUNT, RX_COUNT;
  logic [7:0]  FREQ_EST, CRC_STAT, SIGNAL_STRENGTH_VAL, RX_DATA, TXF_DATA, PWR_LEVEL, st, tdat;
  logic [3:0]  STROBE_CODE, scode;
  logic [63:0] GPO_SOURCES;
  logic [31:0] SYNTH_CAL;
  logic [23:0] TEST_CFG;
  logic [7:0]  wb [8];
  logic [7:0]  rb [8];
  int          checks, fails, ns, ntx, nrx, n0;
  radio_spi_regs #(.PART_ID(PID)) dut (.*);
  radio_spi_host h (.*);
  always @(posedge MCLK) begin
    if (STROBE) begin
      ns++;
      scode = STROBE_CODE;
    end
    if (TXF_WR) begin
      ntx++;
      tdat = TXF_DATA;
    end
    if (RXF_RD) nrx++;
  end
  task automatic frame(input logic [7:0] hdr, input int n);
    h.start();
    h.xfer(hdr, st);
    for (int i = 0; i < n; i++) h.xfer(wb[i], rb[i]);
    h.stop();
  endtask
  task automatic t_reset();
    frame(8'h80, 1);
    `CHK(rb[0], 8'h29)
    `CHK(GPO2, 1'b0)
    CHIP_READY_N <= 1'b1;
    frame(8'hEC, 3);
    `CHK({rb[0], rb[1], rb[2]}, 24'h883100)
    `CHK(GPO2, 1'b1)
  endtask
  task automatic t_gpo2();
    wb[0] = 8'hFF;
    frame(8'h00, 1);
    frame(8'h80, 1);
    `CHK(rb[0], 8'h7F)
    `CHK(GPO2, ~GPO_SOURCES[63])
    wb[0] = 8'h05;
    frame(8'h00, 1);
    `CHK(GPO2, GPO_SOURCES[5])
    frame(8'hF8, 1);
    `CHK(rb[0], {PKT_FLAGS, GPO_SOURCES[5], 1'b0, GPO0_LEVEL})
  endtask
  task automatic t_cal_sleep();
    wb = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h00};
    frame(8'h63, 4);
    `CHK(SYNTH_CAL, 32'h11223344)
    frame(8'h6C, 3);
    `CHK(TEST_CFG, 24'h112233)
    SLEEP <= 1'b1;
    h.tick(20);
    `CHK(TEST_CFG, 24'h883100)
    SLEEP <= 1'b0;
    frame(8'hE3, 4);
    `CHK({rb[0], rb[1], rb[2], rb[3]}, 32'h11223344)
  endtask
  task automatic t_status();
    RADIO_STATE <= 5'h0D;
    TX_UNDERFLOW <= 1'b1;
    TX_COUNT <= 7'h40;
    RX_COUNT <= 7'h21;
    STATUS_MODE <= 3'h2;
    frame(8'hF5, 1);
    `CHK(rb[0], 8'h0D)
    `CHK(st, chip_status_s'({1'b1, 3'h2, 4'hF}))
    frame(8'hFA, 1);
    `CHK(rb[0], 8'hC0)
    frame(8'hFB, 1);
    `CHK(rb[0], {RX_OVERFLOW, 7'h21})
    frame(8'hF0, 1);
    `CHK(rb[0], PID)
    frame(8'hF4, 1);
    `CHK(rb[0], SIGNAL_STRENGTH_VAL)
    n0 = ns;
    frame(8'h36, 0);
    `CHK(ns - n0, 1)
    `CHK(scode, 4'h6)
    frame(8'hBD, 0);
    frame(8'hF6, 1);
    `CHK(rb[0], 8'h00)
    `CHK(ns - n0, 1)
  endtask
  task automatic t_pwr_fifo();
    wb = '{8'hA1, 8'hB2, 8'hC3, 8'h5C, 8'h00, 8'h00, 8'h00, 8'h00};
    frame(8'h7E, 3);
    PWR_SEL <= 3'h1;
    frame(8'hFE, 3);
    `CHK({rb[0], rb[1], rb[2]}, 24'hA1B2C3)
    `CHK(PWR_LEVEL, 8'hB2)
    wb[0] = 8'h5C;
    frame(8'h3F, 1);
    `CHK(ntx, 1)
    `CHK(tdat, 8'h5C)
    frame(8'hBF, 1);
    `CHK(rb[0], RX_DATA)
    `CHK(nrx, 1)
    frame(8'h27, 1);
    frame(8'hA7, 1);
    `CHK(rb[0], 8'h00)
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  initial begin
    #300000;
    fails++;
    conclude();
  end
  initial begin
    {RST, SLEEP, CHIP_READY_N, GPO0_LEVEL, TX_UNDERFLOW, RX_OVERFLOW} = 6'h23;
    {STATUS_MODE, PWR_SEL, RADIO_STATE, PKT_FLAGS} = 16'hA015;
    {TX_COUNT, RX_COUNT} = 14'h0003;
    {FREQ_EST, CRC_STAT, SIGNAL_STRENGTH_VAL, RX_DATA} = 32'h1280346B;
    GPO_SOURCES = 64'hA5C30F965AA53CC3;
    repeat (6) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    t_reset();
    t_gpo2();
    t_cal_sleep();
    t_status();
    t_pwr_fifo();
    RST <= 1'b1;
    h.tick(2);
    RST <= 1'b0;
    h.tick(1);
    frame(8'h80, 1);
    `CHK(rb[0], 8'h29)
    conclude();
  end
endmodule // radio_spi_regs_bench
bind radio_spi_regs radio_spi_regs_checker chk (.MCLK, .RST, .SCLK, .CS_N, .SO, .SO_OE,
  .SLEEP, .STROBE, .STROBE_CODE, .TXF_WR, .RXF_RD, .SYNTH_CAL, .TEST_CFG);

// >>> bench/radio_spi_regs_checker.sv
// Concurrent checks on the ports of the radio register map.
`timescale 1ns/1ps
module radio_spi_regs_checker (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        SCLK,
  input wire logic        CS_N,
  input wire logic        SO,
  input wire logic        SO_OE,
  input wire logic        SLEEP,
  input wire logic        STROBE,
  input wire logic [3:0]  STROBE_CODE,
  input wire logic        TXF_WR,
  input wire logic        RXF_RD,
  input wire logic [31:0] SYNTH_CAL,
  input wire logic [23:0] TEST_CFG
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  sequence s_asleep;
    SLEEP ##1 SLEEP;
  endsequence
  sequence s_idle;
    CS_N [*6];
  endsequence
  property p_oe_off;
    s_idle |-> !SO_OE;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving while deselected");
  property p_oe_on;
    $fell(CS_N) |-> ##[2:5] SO_OE;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("status byte late");
  property p_so_hold;
    SCLK [*4] |-> $stable(SO);
  endproperty
  a_so_hold: assert property (p_so_hold) else $error("data moved in high phase");
  property p_strobe_one;
    STROBE |=> !STROBE;
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe too long");
  property p_nop_quiet;
    STROBE |-> STROBE_CODE != 4'hD;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("no-op pulsed");
  property p_txf_one;
    TXF_WR |=> !TXF_WR;
  endproperty
  a_txf_one: assert property (p_txf_one) else $error("tx write too long");
  property p_rxf_one;
    RXF_RD |=> !RXF_RD;
  endproperty
  a_rxf_one: assert property (p_rxf_one) else $error("rx read too long");
  property p_test_sleep;
    s_asleep |=> TEST_CFG == 24'h883100;
  endproperty
  a_test_sleep: assert property (p_test_sleep) else $error("test regs kept");
  property p_cal_sleep;
    (s_idle ##0 SLEEP) |-> $stable(SYNTH_CAL);
  endproperty
  a_cal_sleep: assert property (p_cal_sleep) else $error("cal regs lost");
endmodule // radio_spi_regs_checker

// >>> core/gpo_pin_mux.sv
// Source selection and polarity for general output pin 2.
`timescale 1ns/1ps
`include "radio_regs_consts.svh"
module gpo_pin_mux (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [6:0]  cfg,
  input  wire logic [63:0] sources,
  output logic             pin
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin <= 1'b1;
    end else begin
      pin <= sources[cfg[`PIN2_SEL_HI:0]] ^ cfg[`PIN2_INV_BIT]; // [RULE8] [RULE9]
    end
  end
endmodule // gpo_pin_mux

// >>> core/radio_regs_consts.svh
// Register addresses, field positions, reset values and header codes of the radio register map.
`ifndef RADIO_REGS_CONSTS_SVH
`define RADIO_REGS_CONSTS_SVH

`define HDR_WRITE_SINGLE 8'h00
`define HDR_BURST        8'h40
`define HDR_READ         8'h80
`define HDR_READ_BURST   8'hC0

`define A_GPO2_CFG   6'h00
`define A_CAL3       6'h23
`define A_CAL2       6'h24
`define A_CAL1       6'h25
`define A_CAL0       6'h26
`define A_TEST_SETTING_2      6'h2C
`define A_TEST_SETTING_1      6'h2D
`define A_TEST_SETTING_0      6'h2E
`define A_STROBE_LO  6'h30
`define A_STROBE_HI  6'h3D
`define A_PART       6'h30
`define A_VERSION    6'h31
`define A_FREQ_OFFSET_ESTIMATE    6'h32
`define A_CRC        6'h33
`define A_SIGNAL_STRENGTH       6'h34
`define A_FSM        6'h35
`define A_PKT        6'h38
`define A_TXLVL      6'h3A
`define A_RXLVL      6'h3B
`define A_NOP        6'h3D
`define A_PWR        6'h3E
`define A_FIFO       6'h3F

`define PIN2_INV_BIT 6
`define PIN2_SEL_HI  5
`define GPO2_RST     7'h29
`define CHIP_RDY_SEL 6'h29
`define CAL_RST      8'h00
`define TEST_SETTING_2_RST    8'h88
`define TEST_SETTING_1_RST    8'h31
`define TEST_SETTING_0_RST    8'h00
`define PWR_RST      8'h00
`define AVAIL_MAX    7'h0F

`endif

// >>> core/radio_regs_pkg.sv
// Types shared by the radio register map modules.
package radio_regs_pkg;

  typedef enum logic [1:0] {
    FR_HDR   = 2'b00,
    FR_WDATA = 2'b01,
    FR_RDATA = 2'b11
  } frame_e;

  typedef struct packed {
    logic       flag;
    logic [6:0] count;
  } fifo_lvl_s;

  typedef struct packed {
    logic       ready_n;
    logic [2:0] state;
    logic [3:0] avail;
  } chip_status_s;

endpackage

// >>> core/radio_spi_regs.sv
// Serial register map of the radio: header decode, registers, status reads and strobes.
//
// How it works
// [RULE1] Header bit 6 selects burst, bit 7 read; four access modes per address.
// [RULE2] Addresses 0x30-0x3D strobe, except burst reads return the status registers.
// [RULE3] Status 0x3A gives transmit underflow flag and transmit byte count.
// [RULE4] Status 0x3B gives receive overflow flag and receive byte count.
// [RULE5] Status 0x38 gives output pin levels and packet reception status.
// [RULE6] Status 0x35 returns the current radio state machine code.
// [RULE7] Calibration registers survive sleep; test registers return to defaults in sleep.
// [RULE8] Pin-2 configuration bit 6 inverts the pin-2 output.
// [RULE9] Pin-2 configuration bits 5:0 pick the pin-2 source, reset 41.
// [RULE10] The no-operation strobe changes nothing; it only yields the status byte.
// [RULE11] 0x3E reaches the power table; 0x3F writes transmit, reads receive buffer.
// [RULE12] Unused addresses and bit 7 of pin-2 configuration read zero, ignore writes.
`timescale 1ns/1ps
`include "radio_regs_consts.svh"
module radio_spi_regs
  import radio_regs_pkg::*;
#(
  parameter logic [7:0] PART_ID   = 8'h5A,
  parameter logic [7:0] REVISION  = 8'h01,
  parameter int         PWR_DEPTH = 8
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        SI,
  output logic             SO,
  output logic             SO_OE,
  input  wire logic        SLEEP,
  input  wire logic        CHIP_READY_N,
  input  wire logic [2:0]  STATUS_MODE,
  input  wire logic [4:0]  RADIO_STATE,
  input  wire logic [7:0]  FREQ_EST,
  input  wire logic [7:0]  CRC_STAT,
  input  wire logic [7:0]  SIGNAL_STRENGTH_VAL,
  input  wire logic [4:0]  PKT_FLAGS,
  input  wire logic        GPO0_LEVEL,
  input  wire logic        TX_UNDERFLOW,
  input  wire logic [6:0]  TX_COUNT,
  input  wire logic        RX_OVERFLOW,
  input  wire logic [6:0]  RX_COUNT,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic [63:0] GPO_SOURCES,
  input  wire logic [2:0]  PWR_SEL,
  output logic             GPO2,
  output logic             STROBE,
  output logic [3:0]       STROBE_CODE,
  output logic             TXF_WR,
  output logic [7:0]       TXF_DATA,
  output logic             RXF_RD,
  output logic [31:0]      SYNTH_CAL,
  output logic [23:0]      TEST_CFG,
  output logic [7:0]       PWR_LEVEL
);
  localparam int IW = $clog2(PWR_DEPTH);

  logic [7:0]    rx_byte;
  logic          byte_done;
  logic          cs_start;
  logic [7:0]    tx_r;
  frame_e        frame_r;
  logic [5:0]    addr_r;
  logic          burst_r;
  logic          load_r;
  logic [6:0]    gpo2_cfg_r;
  logic [7:0]    cal_r [4];
  logic [7:0]    test_setting_2_r;
  logic [7:0]    test_setting_1_r;
  logic [7:0]    test_setting_0_r;
  logic [7:0]    pwr_mem [PWR_DEPTH];
  logic [IW-1:0] pwr_idx_r;
  logic [7:0]    rd_val;
  logic [63:0]   gpo_src;
  logic          is_strobe;
  logic          wr_beat;
  fifo_lvl_s     txl;
  fifo_lvl_s     rxl;
  chip_status_s  chip_st;

  function automatic logic [3:0] sat15(input logic [6:0] n);
    sat15 = (n > `AVAIL_MAX) ? 4'hF : n[3:0];
  endfunction

  function automatic logic in_strobe_range(input logic [5:0] a);
    in_strobe_range = (a >= `A_STROBE_LO) && (a <= `A_STROBE_HI);
  endfunction

  function automatic logic [5:0] next_addr(input logic [5:0] a);
    next_addr = (a >= `A_PWR) ? a : a + 6'h01;
  endfunction

  spi_byte_shifter u_shift (
    .clk       (MCLK),
    .rst       (RST),
    .sclk_pin  (SCLK),
    .cs_n_pin  (CS_N),
    .si_pin    (SI),
    .tx_byte   (tx_r),
    .rx_byte   (rx_byte),
    .byte_done (byte_done),
    .cs_start  (cs_start),
    .so        (SO),
    .so_oe     (SO_OE)
  );

  always_comb begin
    gpo_src                = GPO_SOURCES;
    gpo_src[`CHIP_RDY_SEL] = CHIP_READY_N; // [RULE9]
  end

  gpo_pin_mux u_gpo2 (
    .clk     (MCLK),
    .rst     (RST),
    .cfg     (gpo2_cfg_r),
    .sources (gpo_src),
    .pin     (GPO2)
  );

  assign txl       = '{flag: TX_UNDERFLOW, count: TX_COUNT};
  assign rxl       = '{flag: RX_OVERFLOW, count: RX_COUNT};
  assign chip_st   = '{ready_n: CHIP_READY_N, state: STATUS_MODE, avail: sat15(RX_COUNT)};
  assign is_strobe = in_strobe_range(rx_byte[5:0])
                     && ((rx_byte & `HDR_READ_BURST) != `HDR_READ_BURST); // [RULE2]
  assign wr_beat   = byte_done && (frame_r == FR_WDATA);

  // Frame sequencing: header, then data bytes until a single access ends or select rises.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      frame_r <= FR_HDR;
      addr_r  <= 6'h00;
      burst_r <= 1'b0;
    end else if (cs_start) begin
      frame_r <= FR_HDR;
    end else if (byte_done) begin
      case (frame_r)
        FR_HDR: begin
          addr_r  <= rx_byte[5:0];
          burst_r <= (rx_byte & `HDR_BURST) != `HDR_WRITE_SINGLE; // [RULE1]
          if (is_strobe) begin
            frame_r <= FR_HDR; // [RULE2]
          end else if ((rx_byte & `HDR_READ) != `HDR_WRITE_SINGLE) begin
            frame_r <= FR_RDATA; // [RULE1]
          end else begin
            frame_r <= FR_WDATA;
          end
        end
        FR_WDATA, FR_RDATA: begin
          if (burst_r) begin
            addr_r <= next_addr(addr_r); // [RULE1]
          end else begin
            frame_r <= FR_HDR;
          end
        end
        default: begin
          frame_r <= FR_HDR;
        end
      endcase
    end
  end

  // Read data multiplexer; status codes are reached only by burst reads.
  always_comb begin
    case (addr_r)
      `A_GPO2_CFG: rd_val = {1'b0, gpo2_cfg_r}; // [RULE12]
      `A_CAL3:     rd_val = cal_r[3];
      `A_CAL2:     rd_val = cal_r[2];
      `A_CAL1:     rd_val = cal_r[1];
      `A_CAL0:     rd_val = cal_r[0];
      `A_TEST_SETTING_2:    rd_val = test_setting_2_r;
      `A_TEST_SETTING_1:    rd_val = test_setting_1_r;
      `A_TEST_SETTING_0:    rd_val = test_setting_0_r;
      `A_PART:     rd_val = PART_ID; // [RULE2]
      `A_VERSION:  rd_val = REVISION;
      `A_FREQ_OFFSET_ESTIMATE:  rd_val = FREQ_EST;
      `A_CRC:      rd_val = CRC_STAT;
      `A_SIGNAL_STRENGTH:     rd_val = SIGNAL_STRENGTH_VAL;
      `A_FSM:      rd_val = {3'h0, RADIO_STATE}; // [RULE6]
      `A_PKT:      rd_val = {PKT_FLAGS, GPO2, 1'b0, GPO0_LEVEL}; // [RULE5]
      `A_TXLVL:    rd_val = txl; // [RULE3]
      `A_RXLVL:    rd_val = rxl; // [RULE4]
      `A_PWR:      rd_val = pwr_mem[pwr_idx_r]; // [RULE11]
      `A_FIFO:     rd_val = RX_DATA; // [RULE11]
      default:     rd_val = 8'h00; // [RULE12]
    endcase
  end

  // Outgoing byte: status byte in header slots, register data in read slots.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      load_r <= 1'b0;
      tx_r   <= 8'h00;
    end else begin
      load_r <= byte_done;
      if (cs_start) begin
        tx_r <= chip_st; // [RULE10]
      end else if (load_r) begin
        tx_r <= (frame_r == FR_RDATA) ? rd_val : chip_st;
      end
    end
  end

  // Strobe pulses; the no-operation code gives no pulse.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      STROBE      <= 1'b0;
      STROBE_CODE <= 4'h0;
    end else begin
      STROBE <= 1'b0;
      if (byte_done && frame_r == FR_HDR && is_strobe && rx_byte[5:0] != `A_NOP) begin // [RULE10]
        STROBE      <= 1'b1; // [RULE2]
        STROBE_CODE <= rx_byte[3:0];
      end
    end
  end

  // Transmit buffer writes and receive buffer reads.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      TXF_WR   <= 1'b0;
      TXF_DATA <= 8'h00;
      RXF_RD   <= 1'b0;
    end else begin
      TXF_WR <= 1'b0;
      RXF_RD <= 1'b0;
      if (wr_beat && addr_r == `A_FIFO) begin
        TXF_WR   <= 1'b1; // [RULE11]
        TXF_DATA <= rx_byte;
      end
      if (load_r && frame_r == FR_RDATA && addr_r == `A_FIFO) begin
        RXF_RD <= 1'b1; // [RULE11]
      end
    end
  end

  // Pin-2 configuration; bit 7 is not stored.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      gpo2_cfg_r <= `GPO2_RST; // [RULE9]
    end else if (wr_beat && addr_r == `A_GPO2_CFG) begin
      gpo2_cfg_r <= rx_byte[6:0]; // [RULE8] [RULE12]
    end
  end

  // Calibration registers ignore sleep.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 4; i++) begin
        cal_r[i] <= `CAL_RST;
      end
    end else if (wr_beat && addr_r >= `A_CAL3 && addr_r <= `A_CAL0) begin
      cal_r[2'(`A_CAL0 - addr_r)] <= rx_byte; // [RULE7]
    end
  end

  // Test registers fall back to defaults while sleeping.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      test_setting_2_r <= `TEST_SETTING_2_RST;
      test_setting_1_r <= `TEST_SETTING_1_RST;
      test_setting_0_r <= `TEST_SETTING_0_RST;
    end else if (SLEEP) begin
      test_setting_2_r <= `TEST_SETTING_2_RST; // [RULE7]
      test_setting_1_r <= `TEST_SETTING_1_RST;
      test_setting_0_r <= `TEST_SETTING_0_RST;
    end else if (wr_beat) begin
      if (addr_r == `A_TEST_SETTING_2) begin
        test_setting_2_r <= rx_byte;
      end
      if (addr_r == `A_TEST_SETTING_1) begin
        test_setting_1_r <= rx_byte;
      end
      if (addr_r == `A_TEST_SETTING_0) begin
        test_setting_0_r <= rx_byte;
      end
    end
  end

  // Power table with an index that advances per access and rewinds at select.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pwr_idx_r <= '0;
      for (int i = 0; i < PWR_DEPTH; i++) begin
        pwr_mem[i] <= `PWR_RST;
      end
    end else if (cs_start) begin
      pwr_idx_r <= '0;
    end else if (wr_beat && addr_r == `A_PWR) begin
      pwr_mem[pwr_idx_r] <= rx_byte; // [RULE11]
      pwr_idx_r          <= pwr_idx_r + 1'b1;
    end else if (load_r && frame_r == FR_RDATA && addr_r == `A_PWR) begin
      pwr_idx_r <= pwr_idx_r + 1'b1;
    end
  end

  // Register images driven to the radio.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      SYNTH_CAL <= '0;
      TEST_CFG  <= '0;
      PWR_LEVEL <= 8'h00;
    end else begin
      SYNTH_CAL <= {cal_r[3], cal_r[2], cal_r[1], cal_r[0]};
      TEST_CFG  <= {test_setting_2_r, test_setting_1_r, test_setting_0_r};
      PWR_LEVEL <= pwr_mem[PWR_SEL[IW-1:0]];
    end
  end
endmodule // radio_spi_regs

// >>> core/spi_byte_shifter.sv
// Serial port byte shifter with pin synchronisers and clock edge detection.
`timescale 1ns/1ps
module spi_byte_shifter (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sclk_pin,
  input  wire logic       cs_n_pin,
  input  wire logic       si_pin,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            byte_done,
  output logic            cs_start,
  output logic            so,
  output logic            so_oe
);
  logic [1:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] si_s;
  logic       sclk_d;
  logic       cs_d;
  logic [2:0] cnt_r;
  logic [6:0] in_r;
  logic [7:0] out_r;
  logic       rise;
  logic       fall;
  logic       active;
  logic       start_d;

  assign rise   = sclk_s[1] & ~sclk_d;
  assign fall   = ~sclk_s[1] & sclk_d;
  assign active = ~cs_s[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_s <= 2'b00;
      cs_s   <= 2'b11;
      si_s   <= 2'b00;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], sclk_pin};
      cs_s   <= {cs_s[0], cs_n_pin};
      si_s   <= {si_s[0], si_pin};
      sclk_d <= sclk_s[1];
      cs_d   <= cs_s[1];
    end
  end

  // Input bits are sampled on the rising serial clock edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r     <= 3'h0;
      in_r      <= 7'h00;
      rx_byte   <= 8'h00;
      byte_done <= 1'b0;
      cs_start  <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      cs_start  <= cs_d & ~cs_s[1];
      if (!active) begin
        cnt_r <= 3'h0;
      end else if (rise) begin
        in_r  <= {in_r[5:0], si_s[1]};
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h7) begin
          rx_byte   <= {in_r, si_s[1]};
          byte_done <= 1'b1;
        end
      end
    end
  end

  // Output bits change on the falling edge; a new byte is taken at each byte start.
  // The first byte is taken one cycle after the select pulse, once the status byte is loaded.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_r   <= 8'h00;
      so      <= 1'b0;
      so_oe   <= 1'b0;
      start_d <= 1'b0;
    end else begin
      so_oe   <= active;
      start_d <= cs_start;
      if (start_d || (active && fall && cnt_r == 3'h0)) begin
        so    <= tx_byte[7];
        out_r <= {tx_byte[6:0], 1'b0};
      end else if (active && fall) begin
        so    <= out_r[7];
        out_r <= {out_r[6:0], 1'b0};
      end
    end
  end
endmodule // spi_byte_shifter
